// file: spk_consts.svh
// Constants for the speech chip parameter host port
`ifndef SPK_CONSTS_SVH
`define SPK_CONSTS_SVH
// Operation codes {rw, addr_msb, addr_lsb}
`define SPK_OP_CTRL_WR 3'h0
`define SPK_OP_PTR_WR 3'h1
`define SPK_OP_DIN_WR0 3'h2
`define SPK_OP_DIN_WR1 3'h3
`define SPK_OP_STAT_RD 3'h4
`define SPK_OP_NONE_RD 3'h5
`define SPK_OP_DOUT_RD 3'h6
`define SPK_OP_FETCH_RD 3'h7
// Status and pointer fields
`define SPK_STAT_BUSY_BIT 7
`define SPK_PTR_BUF_BIT 5
`define SPK_PTR_IDX_MSB 3
// Reset values
`define SPK_CTRL_RST 8'h00
`define SPK_PTR_RST 8'h00
// Parameter counts and last index per mode
`define SPK_SYN_LAST 4'he
`define SPK_REC_LAST 4'hb
`define SPK_SR_IDX 4'hb
// Control bit that selects recognition mode in this model
`define SPK_CTRL_REC_BIT 0
// Sample period: bit slots per recirculation
`define SPK_SLOT_BITS 9
`define SPK_SLOTS 16
// PWM width for the speech output
`define SPK_PWM_BITS 8
`endif

// file: spk_pkg.sv
// Types for the speech chip parameter host port
package spk_pkg;
    // Parameter access engine states
    typedef enum logic [1:0] {
        SPK_IDLE,
        SPK_STORE,
        SPK_FETCH
    } spk_acc_e;
    // Nine-bit parameter word
    typedef logic [8:0] spk_word_t;
endpackage : spk_pkg

// file: spk_param_ring.sv
// Recirculating bit-serial parameter store with one access point
`timescale 1ns/100ps
`include "spk_consts.svh"
module spk_param_ring #(
    parameter int SLOTS = `SPK_SLOTS,
    parameter int BITS = `SPK_SLOT_BITS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Access point
    input wire logic wr_en,
    input wire logic wr_bit,
    output logic rd_bit,
    output logic [3:0] slot_idx,
    output logic [3:0] bit_idx,
    output logic slot_end
);
    // Serial ring, one bit leaves the access point each clock
    logic [SLOTS*BITS-1:0] ring_reg;
    // Position counters
    logic [3:0] slot_reg;
    logic [3:0] bit_reg;

    // Position of the bit now at the access point
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            slot_reg <= 4'h0;
            bit_reg <= 4'h0;
        end else if (bit_reg == 4'(BITS - 1)) begin
            bit_reg <= 4'h0;
            slot_reg <= 4'(slot_reg + 4'h1);
        end else begin
            bit_reg <= 4'(bit_reg + 4'h1);
        end
    end

    // Recirculate; the access point may overwrite the passing bit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ring_reg <= '0;
        end else begin
            ring_reg <= {wr_en ? wr_bit : ring_reg[0], ring_reg[SLOTS*BITS-1:1]}; // RULE7
        end
    end

    assign rd_bit = ring_reg[0];
    assign slot_idx = slot_reg;
    assign bit_idx = bit_reg;
    assign slot_end = (bit_reg == 4'(BITS - 1));
endmodule : spk_param_ring

// file: spk_pwm.sv
// Eight-bit pulse width modulator for the speech output
`timescale 1ns/100ps
`include "spk_consts.svh"
module spk_pwm #(
    parameter int WIDTH = `SPK_PWM_BITS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Sample in, pulse out
    input wire logic [WIDTH-1:0] level,
    output logic pwm_out
);
    // Free running ramp
    logic [WIDTH-1:0] ramp_reg;

    // Ramp and compare; output registered to stay glitch free
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ramp_reg <= '0;
            pwm_out <= 1'b0;
        end else begin
            ramp_reg <= WIDTH'(ramp_reg + 1'b1);
            pwm_out <= (ramp_reg < level); // RULE17
        end
    end
endmodule : spk_pwm

// file: spk_host_port.sv
// Parameter host port of the speech chip: bus decode, busy handshake, wait, outputs
//
// Operation
// RULE1: Selected only when strobe high, select low
// RULE2: Data moves only when selected, rw decides
// RULE3: Code 0 loads control, code 1 pointer
// RULE4: Codes 2,3 load nine-bit input word
// RULE5: Code 4 reads status; code 5 undefined
// RULE6: Codes 6,7 read output; 7 fetches
// RULE7: Parameters live in recirculating serial rings
// RULE8: Input register write sets busy
// RULE9: Store at access point, then clear busy
// RULE10: Fetch sets busy while pending
// RULE11: Fetch copies eight bits, clears busy
// RULE12: Host polls busy, leaves port alone
// RULE13: Wait low for codes 1,2,3,7 while busy
// RULE14: Wait stays low until unbusy or deselect
// RULE15: Low reset pin resets the device
// RULE16: System clock is crystal halved, driven out
// RULE17: Speech output is eight-bit PWM
// RULE18: Three gain select outputs drive switches
// RULE19: Busy is status bit 7
// RULE20: Pointer bits 0-3 index, bit 5 buffer
// RULE21: Pointer advances after each access
// RULE22: Control register is plain storage
`timescale 1ns/100ps
`include "spk_consts.svh"
module spk_host_port (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Device pins, asynchronous to clk_sys
    input wire logic reset_pin_n,
    input wire logic strobe,
    input wire logic chip_select_low_n,
    input wire logic rw,
    input wire logic addr_msb,
    input wire logic addr_lsb_ninth_bit,
    // Data bus, split three ways
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Open-drain wait, oe high pulls the pin low
    output logic wait_out,
    output logic wait_oe,
    // Clock pin, test input or buffered output
    input wire logic crystal_input,
    output logic crystal_output,
    input wire logic clock_pin_in,
    input wire logic ext_clock_sel,
    output logic clock_pin_out,
    output logic clock_pin_oe,
    output logic osc_enable,
    // Analog side
    output logic speech_pwm,
    output logic [2:0] gain_sel
);
    // Pin synchronisers, first stage read only by second
    logic [13:0] pin_s1_reg;
    logic [13:0] pin_s2_reg;
    // Synchronised pin copies
    logic rst_pin_n_s;
    logic strobe_s;
    logic cs_n_s;
    logic rw_s;
    logic a1_s;
    logic a0_s;
    logic [7:0] din_s;
    // Select history for edge detection
    logic sel_d_reg;
    // Internal reset from either source
    logic dev_rst;
    // Host visible registers
    logic [7:0] control_word_reg;
    logic [7:0] parameter_pointer_reg;
    spk_pkg::spk_word_t parameter_write_holding_reg;
    logic [7:0] parameter_read_holding_reg;
    logic busy_reg;
    // Access engine
    spk_pkg::spk_acc_e acc_reg;
    logic [7:0] fetch_sh_reg;
    // Set while the addressed slot streams past
    logic armed_reg;
    // Wait latch
    logic wait_reg;
    // Clock divider
    logic half_clk_reg;
    // Gain and PWM sample
    logic [2:0] gain_reg;
    logic [7:0] pwm_level_reg;
    // Decode
    logic sel;
    logic sel_rise;
    logic [2:0] op;
    // Ring signals
    logic ring_wr_en;
    logic ring_wr_bit;
    logic ring_rd_bit;
    logic [3:0] ring_slot;
    logic [3:0] ring_bit;
    logic ring_slot_end;
    logic at_target;

    // Returns the last index of the active mode sequence
    function automatic logic [3:0] last_idx(input logic rec);
        last_idx = rec ? `SPK_REC_LAST : `SPK_SYN_LAST;
    endfunction : last_idx

    // Next pointer: walk the index, wrap to first; buffer bit only for SR
    function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic rec);
        logic [3:0] idx;
        idx = (p[3:0] >= last_idx(rec)) ? 4'h0 : 4'(p[3:0] + 4'h1);
        next_ptr = 8'h00;
        next_ptr[3:0] = idx;
        next_ptr[`SPK_PTR_BUF_BIT] = rec && (idx == `SPK_SR_IDX); // RULE20
    endfunction : next_ptr

    // Two flip-flop synchronisers on every bus and reset pin input
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_s1_reg <= 14'h0003;
            pin_s2_reg <= 14'h0003;
        end else begin
            pin_s1_reg <= {strobe, rw, addr_msb, data_in, addr_lsb_ninth_bit,
                chip_select_low_n, reset_pin_n};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Pin fields from the second stage only; one bank keeps them in step
    assign rst_pin_n_s = pin_s2_reg[0];
    assign cs_n_s = pin_s2_reg[1];
    assign a0_s = pin_s2_reg[2];
    assign din_s = pin_s2_reg[10:3];
    assign a1_s = pin_s2_reg[11];
    assign rw_s = pin_s2_reg[12];
    assign strobe_s = pin_s2_reg[13];

    // Reset pin low or system reset both clear the device
    assign dev_rst = srst || !rst_pin_n_s; // RULE15

    // Select only when strobe high and select low
    assign sel = strobe_s && !cs_n_s; // RULE1
    assign op = {rw_s, a1_s, a0_s};
    assign sel_rise = sel && !sel_d_reg;

    // Select edge history; one action per bus cycle
    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            sel_d_reg <= 1'b0;
        end else begin
            sel_d_reg <= sel;
        end
    end

    // Host writes, taken at the select edge; busy blocks parameter writes
    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            control_word_reg <= `SPK_CTRL_RST;
        end else if (sel_rise && op == `SPK_OP_CTRL_WR) begin
            control_word_reg <= din_s; // RULE3 RULE22
        end
    end

    // Parameter write holding, loaded only when empty
    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            parameter_write_holding_reg <= '0;
        end else if (sel_rise && !busy_reg && !rw_s && a1_s) begin
            parameter_write_holding_reg <= {din_s, a0_s}; // RULE4
        end
    end

    // Ring target: addressed slot at the access point, entered only at its
    // first bit so a request arriving mid-slot never moves a torn word
    assign at_target = (ring_slot == parameter_pointer_reg[3:0])
        && (ring_bit == 4'h0 || armed_reg);

    // Slot entry flag, held from the first bit to the last
    always_ff @(posedge clk_sys) begin
        if (dev_rst || acc_reg == spk_pkg::SPK_IDLE) begin
            armed_reg <= 1'b0;
        end else if (at_target) begin
            armed_reg <= !ring_slot_end; // RULE7
        end
    end

    // Access engine: busy, store and fetch
    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            acc_reg <= spk_pkg::SPK_IDLE;
            busy_reg <= 1'b0;
            parameter_pointer_reg <= `SPK_PTR_RST;
            parameter_read_holding_reg <= 8'h00;
            fetch_sh_reg <= 8'h00;
        end else begin
            case (acc_reg)
                spk_pkg::SPK_IDLE: begin
                    if (sel_rise && op == `SPK_OP_PTR_WR) begin
                        parameter_pointer_reg <= din_s; // RULE3 RULE20
                    end else if (sel_rise && !rw_s && a1_s) begin
                        acc_reg <= spk_pkg::SPK_STORE;
                        busy_reg <= 1'b1; // RULE8
                    end else if (sel_rise && op == `SPK_OP_FETCH_RD) begin
                        acc_reg <= spk_pkg::SPK_FETCH;
                        busy_reg <= 1'b1; // RULE10
                    end
                end
                spk_pkg::SPK_STORE: begin
                    // Wait for the last bit of the addressed slot
                    if (at_target && ring_slot_end) begin
                        acc_reg <= spk_pkg::SPK_IDLE;
                        busy_reg <= 1'b0; // RULE9
                        parameter_pointer_reg <= next_ptr(parameter_pointer_reg,
                            control_word_reg[`SPK_CTRL_REC_BIT]); // RULE21
                    end
                end
                spk_pkg::SPK_FETCH: begin
                    if (at_target) begin
                        // Keep the upper eight of nine bits as they pass
                        fetch_sh_reg <= {ring_rd_bit, fetch_sh_reg[7:1]};
                    end
                    if (at_target && ring_slot_end) begin
                        acc_reg <= spk_pkg::SPK_IDLE;
                        busy_reg <= 1'b0; // RULE11
                        parameter_read_holding_reg <= {ring_rd_bit, fetch_sh_reg[7:1]};
                        parameter_pointer_reg <= next_ptr(parameter_pointer_reg,
                            control_word_reg[`SPK_CTRL_REC_BIT]); // RULE21
                    end
                end
                default: begin
                    acc_reg <= spk_pkg::SPK_IDLE;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // Store streams the holding word lsb first into the addressed slot
    assign ring_wr_en = (acc_reg == spk_pkg::SPK_STORE) && at_target; // RULE9
    assign ring_wr_bit = parameter_write_holding_reg[ring_bit];

    // Serial parameter ring
    spk_param_ring #(
        .SLOTS(`SPK_SLOTS),
        .BITS(`SPK_SLOT_BITS)
    ) u_ring (
        .clk_sys(clk_sys),
        .srst(dev_rst),
        .wr_en(ring_wr_en),
        .wr_bit(ring_wr_bit),
        .rd_bit(ring_rd_bit),
        .slot_idx(ring_slot),
        .bit_idx(ring_bit),
        .slot_end(ring_slot_end)
    );

    // Read data, registered; driven only while selected for a read
    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            data_oe <= sel && rw_s; // RULE2
            case (op)
                `SPK_OP_STAT_RD: data_out <= {busy_reg, 7'h00}; // RULE5 RULE19
                `SPK_OP_DOUT_RD, `SPK_OP_FETCH_RD: data_out <= parameter_read_holding_reg; // RULE6
                default: data_out <= 8'h00; // Code 5 and writes read zero
            endcase
        end
    end

    // Wait: set on selected code 1,2,3,7 while busy, held till unbusy or deselect
    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            wait_reg <= 1'b0;
        end else if (!sel || !busy_reg) begin
            wait_reg <= 1'b0; // RULE14
        end else if (op == `SPK_OP_PTR_WR || op == `SPK_OP_DIN_WR0
                || op == `SPK_OP_DIN_WR1 || op == `SPK_OP_FETCH_RD) begin
            wait_reg <= 1'b1; // RULE13
        end
    end
    assign wait_out = 1'b0;
    assign wait_oe = wait_reg;

    // Clock pin: drive clk_sys halved unless an external clock is chosen
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            half_clk_reg <= 1'b0;
        end else begin
            half_clk_reg <= !half_clk_reg; // RULE16
        end
    end
    assign clock_pin_out = half_clk_reg;
    assign clock_pin_oe = !ext_clock_sel;
    assign osc_enable = !ext_clock_sel; // RULE16
    assign crystal_output = osc_enable && !crystal_input;

    // Speech level from stored parameter words, gain from the control word
    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            pwm_level_reg <= 8'h00;
            gain_reg <= 3'h0;
        end else begin
            if (acc_reg == spk_pkg::SPK_STORE && at_target && ring_slot_end) begin
                pwm_level_reg <= parameter_write_holding_reg[8:1];
            end
            gain_reg <= control_word_reg[3:1]; // RULE18
        end
    end
    assign gain_sel = gain_reg;

    // Speech output modulator
    spk_pwm #(
        .WIDTH(`SPK_PWM_BITS)
    ) u_pwm (
        .clk_sys(clk_sys),
        .srst(dev_rst),
        .level(pwm_level_reg),
        .pwm_out(speech_pwm)
    );

    // Busy must set after a store request is taken
    property p_busy_on_store;
        @(posedge clk_sys) disable iff (dev_rst)
        (acc_reg == spk_pkg::SPK_IDLE && sel_rise && !rw_s && a1_s)
            |=> busy_reg;
    endproperty
    a_busy_on_store: assert property (p_busy_on_store) else $error("busy not set"); // RULE8

    // Fetch sets busy
    property p_busy_on_fetch;
        @(posedge clk_sys) disable iff (dev_rst)
        (acc_reg == spk_pkg::SPK_IDLE && sel_rise && op == `SPK_OP_FETCH_RD
            && !(op == `SPK_OP_PTR_WR)) |=> busy_reg && acc_reg == spk_pkg::SPK_FETCH;
    endproperty
    a_busy_on_fetch: assert property (p_busy_on_fetch) else $error("fetch not busy"); // RULE10

    // Busy clears within 160 clocks, longer than one ring revolution
    property p_busy_bounded;
        @(posedge clk_sys) disable iff (dev_rst)
        $rose(busy_reg) |-> ##[1:160] !busy_reg;
    endproperty
    a_busy_bounded: assert property (p_busy_bounded) else $error("busy stuck"); // RULE9

    // Busy is status bit 7
    property p_status_busy;
        @(posedge clk_sys) disable iff (dev_rst)
        (op == `SPK_OP_STAT_RD) |=> data_out[7] == $past(busy_reg) && data_out[6:0] == 7'h00;
    endproperty
    a_status_busy: assert property (p_status_busy) else $error("status wrong"); // RULE19

    // Data driven only for selected reads
    property p_data_oe;
        @(posedge clk_sys) disable iff (dev_rst)
        data_oe |-> $past(sel) && $past(rw_s);
    endproperty
    a_data_oe: assert property (p_data_oe) else $error("bus driven unselected"); // RULE2

    // Wait only while selected and busy
    property p_wait_cause;
        @(posedge clk_sys) disable iff (dev_rst)
        wait_oe |-> $past(sel) && $past(busy_reg);
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("wait without cause"); // RULE14

    // Wait asserts for a blocked pointer write
    property p_wait_set;
        @(posedge clk_sys) disable iff (dev_rst)
        (sel && busy_reg && op == `SPK_OP_PTR_WR) |=> wait_oe;
    endproperty
    a_wait_set: assert property (p_wait_set) else $error("wait missing"); // RULE13

    // Pointer advances on completion
    property p_ptr_advance;
        @(posedge clk_sys) disable iff (dev_rst)
        (acc_reg != spk_pkg::SPK_IDLE && at_target && ring_slot_end)
            |=> parameter_pointer_reg[3:0] != $past(parameter_pointer_reg[3:0]);
    endproperty
    a_ptr_advance: assert property (p_ptr_advance) else $error("pointer stuck"); // RULE21
endmodule : spk_host_port

// file: spk_host_model.sv
// Host processor model that drives the parameter port pins
`timescale 1ns/100ps
module spk_host_model #(
    parameter int HOLD = 6,
    parameter int GAP = 4
) (
    // Clock
    input wire logic clk_sys,
    // Pins driven by the host
    output logic strobe,
    output logic chip_select_low_n,
    output logic rw,
    output logic addr_msb,
    output logic addr_lsb_ninth_bit,
    output logic [7:0] data_in,
    // Read side of the data bus
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    // Idle state: chip not selected
    initial begin
        strobe = 1'b0;
        chip_select_low_n = 1'b1;
        rw = 1'b1;
        addr_msb = 1'b0;
        addr_lsb_ninth_bit = 1'b0;
        data_in = 8'h00;
    end
    // Present one code; all qualifiers change together just after an edge
    task automatic select(input logic [2:0] code, input logic [7:0] d,
                          input logic stb, input logic csn);
        @(posedge clk_sys);
        rw <= code[2];
        addr_msb <= code[1];
        addr_lsb_ninth_bit <= code[0];
        data_in <= d;
        strobe <= stb;
        chip_select_low_n <= csn;
    endtask : select
    // Release; data lines flip so a stale value is never mistaken for live
    task automatic deselect();
        @(posedge clk_sys);
        strobe <= 1'b0;
        chip_select_low_n <= 1'b1;
        data_in <= ~data_in;
        repeat (GAP) @(posedge clk_sys);
    endtask : deselect
    // Whole bus cycle; the pins are synced inside, so hold for HOLD edges
    task automatic cycle(input logic [2:0] code, input logic [7:0] d, input logic stb,
                         input logic csn, output logic [7:0] q, output logic oe);
        select(code, d, stb, csn);
        repeat (HOLD) @(posedge clk_sys);
        q = data_out;
        oe = data_oe;
        deselect();
    endtask : cycle
    // Ordinary selected operation
    task automatic op(input logic [2:0] code, input logic [7:0] d,
                      output logic [7:0] q, output logic oe);
        cycle(code, d, 1'b1, 1'b0, q, oe);
    endtask : op
    // Poll status until busy drops, bounded
    task automatic poll(output logic ok);
        logic [7:0] s;
        logic e;
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            op(3'h4, 8'h00, s, e);
            ok = (s[7] === 1'b0);
        end
    endtask : poll
endmodule : spk_host_model

// file: tb_top.sv
// Self-checking testbench for the parameter host port
`timescale 1ns/100ps
module tb_top;
    // Clock, resets and pins
    logic clk_sys;
    logic srst;
    logic reset_pin_n;
    logic strobe;
    logic chip_select_low_n;
    logic rw;
    logic addr_msb;
    logic addr_lsb_ninth_bit;
    logic [7:0] data_in;
    logic [7:0] data_out;
    logic data_oe;
    logic wait_out;
    logic wait_oe;
    logic wait_pin;
    logic crystal_input;
    logic crystal_output;
    logic ext_clock_sel;
    logic clock_pin_out;
    logic clock_pin_oe;
    logic osc_enable;
    logic speech_pwm;
    logic [2:0] gain_sel;
    // Bookkeeping
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    // Open-drain wait pin with its pull-up
    assign wait_pin = wait_oe ? wait_out : 1'b1;
    // Device under test
    spk_host_port i_dut (.clk_sys(clk_sys), .srst(srst), .reset_pin_n(reset_pin_n),
        .strobe(strobe), .chip_select_low_n(chip_select_low_n), .rw(rw),
        .addr_msb(addr_msb), .addr_lsb_ninth_bit(addr_lsb_ninth_bit),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .wait_out(wait_out), .wait_oe(wait_oe), .crystal_input(crystal_input),
        .crystal_output(crystal_output), .clock_pin_in(1'b0),
        .ext_clock_sel(ext_clock_sel), .clock_pin_out(clock_pin_out),
        .clock_pin_oe(clock_pin_oe), .osc_enable(osc_enable),
        .speech_pwm(speech_pwm), .gain_sel(gain_sel));
    // Host on the far side
    spk_host_model i_host (.clk_sys(clk_sys), .strobe(strobe),
        .chip_select_low_n(chip_select_low_n), .rw(rw), .addr_msb(addr_msb),
        .addr_lsb_ninth_bit(addr_lsb_ninth_bit), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe));
    // One comparison
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    // Idle outputs and the clock pins after reset
    task automatic t_reset();
        logic a;
        @(posedge clk_sys);
        #1;
        check("idle data_oe", data_oe, 0);
        check("idle wait", wait_pin, 1);
        check("crystal out", crystal_output, !crystal_input);
        check("osc enable", osc_enable, 1);
        a = clock_pin_out;
        @(posedge clk_sys);
        #1;
        check("clock out", clock_pin_out, !a);
    endtask : t_reset
    // Control writes, with each select half missing in turn
    task automatic t_select();
        logic [7:0] q;
        logic oe;
        i_host.op(3'h0, 8'h0e, q, oe);
        check("gain", gain_sel, 3'h7);
        i_host.cycle(3'h0, 8'h00, 1'b0, 1'b0, q, oe);
        check("gain strobe low", gain_sel, 3'h7);
        i_host.cycle(3'h0, 8'h00, 1'b1, 1'b1, q, oe);
        check("gain cs high", gain_sel, 3'h7);
        i_host.cycle(3'h4, 8'h00, 1'b1, 1'b1, q, oe);
        check("oe unselected", oe, 0);
        i_host.op(3'h0, 8'h0a, q, oe);
        check("oe on write", oe, 0);
        check("gain", gain_sel, 3'h5);
    endtask : t_select
    // Status and the unused read code
    task automatic t_status();
        logic [7:0] q;
        logic oe;
        i_host.op(3'h4, 8'h00, q, oe);
        check("busy idle", q[7], 0);
        check("status oe", oe, 1);
        i_host.op(3'h5, 8'h00, q, oe);
        check("code 5", q, 8'h00);
    endtask : t_status
    // Fetch aligns the ring, then stores, refused write, wait, fetch back
    task automatic t_store_fetch();
        logic [7:0] q;
        logic oe;
        logic ok;
        i_host.op(3'h1, 8'h02, q, oe);
        i_host.op(3'h7, 8'h00, q, oe);
        i_host.poll(ok);
        check("align fetch", ok, 1);
        // Slot 2 just passed, so the store below waits most of a period
        i_host.op(3'h1, 8'h02, q, oe);
        i_host.op(3'h3, 8'h5a, q, oe);
        i_host.op(3'h4, 8'h00, q, oe);
        check("busy after store", q[7], 1);
        i_host.select(3'h2, 8'h11, 1'b1, 1'b0);
        repeat (6) @(posedge clk_sys);
        #1;
        check("wait while busy", wait_pin, 0);
        i_host.deselect();
        #1;
        check("wait on deselect", wait_pin, 1);
        i_host.poll(ok);
        check("store done", ok, 1);
        i_host.op(3'h2, 8'hc3, q, oe);
        i_host.poll(ok);
        check("second store", ok, 1);
        i_host.op(3'h1, 8'h02, q, oe);
        i_host.op(3'h7, 8'h00, q, oe);
        i_host.poll(ok);
        i_host.op(3'h6, 8'h00, q, oe);
        check("fetch index 2", q, 8'h5a);
        i_host.op(3'h7, 8'h00, q, oe);
        check("code 7 data", q, 8'h5a);
        i_host.poll(ok);
        i_host.op(3'h6, 8'h00, q, oe);
        check("fetch index 3", q, 8'hc3);
    endtask : t_store_fetch
    // Recognition mode wraps the pointer after index b
    task automatic t_rec();
        logic [7:0] q;
        logic oe;
        logic ok;
        i_host.op(3'h0, 8'h0b, q, oe);
        i_host.op(3'h1, 8'h0b, q, oe);
        i_host.op(3'h2, 8'h3c, q, oe);
        i_host.poll(ok);
        i_host.op(3'h2, 8'h69, q, oe);
        i_host.poll(ok);
        i_host.op(3'h1, 8'h00, q, oe);
        i_host.op(3'h7, 8'h00, q, oe);
        i_host.poll(ok);
        i_host.op(3'h6, 8'h00, q, oe);
        check("rec wrap", q, 8'h69);
    endtask : t_rec
    // Duty over two PWM periods follows the last stored word
    task automatic t_pwm();
        int n;
        n = 0;
        repeat (512) begin
            @(posedge clk_sys);
            #1;
            if (speech_pwm === 1'b1) begin
                n++;
            end
        end
        check("pwm duty", (n >= 386 && n <= 394), 1);
    endtask : t_pwm
    // External clock selection stops the oscillator
    task automatic t_clock();
        @(posedge clk_sys);
        ext_clock_sel <= 1'b1;
        @(posedge clk_sys);
        #1;
        check("osc off", osc_enable, 0);
        check("clock pin oe", clock_pin_oe, 0);
        @(posedge clk_sys);
        ext_clock_sel <= 1'b0;
    endtask : t_clock
    // Reset pin low clears the control word
    task automatic t_reset_pin();
        @(posedge clk_sys);
        reset_pin_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        reset_pin_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        check("gain after pin reset", gain_sel, 3'h0);
    endtask : t_reset_pin
    // Clock source
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Crystal toggling and hang guard
    always @(posedge clk_sys) begin
        crystal_input <= !crystal_input;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // Main sequence
    initial begin
        srst = 1'b1;
        reset_pin_n = 1'b1;
        crystal_input = 1'b0;
        ext_clock_sel = 1'b0;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_select();
        t_status();
        t_store_fetch();
        t_pwm();
        t_rec();
        t_clock();
        t_reset_pin();
        tally_and_finish();
    end
endmodule : tb_top
